// ---- hw/bec_pkg.sv ----
package bec_pkg;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   // Clock period, 20 ns
   localparam int unsigned CLK_PERIOD_NS     = 32'h14;
   // Bias start-up and selection evaluation, 220000 ns
   localparam int unsigned STARTUP_DELAY_NS  = 32'h35B60;
   localparam int unsigned STARTUP_DELAY_CYC =
      (STARTUP_DELAY_NS + CLK_PERIOD_NS - 32'h1) / CLK_PERIOD_NS;
   // Loss of external tracking clock, 4000 ns
   localparam int unsigned TRACK_TIMEOUT_NS  = 32'hFA0;
   localparam int unsigned TRACK_TIMEOUT_CYC =
      (TRACK_TIMEOUT_NS + CLK_PERIOD_NS - 32'h1) / CLK_PERIOD_NS;

   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam logic [7:0] ADR_CTRL    = 8'h00;
   localparam logic [7:0] ADR_STATUS  = 8'h04;
   localparam logic [7:0] ADR_EVENT   = 8'h08;
   localparam logic [7:0] ADR_DEFAULT = 8'h0C;

   localparam int unsigned NUM_OUT      = 32'h2;
   localparam int unsigned SEL_W        = 32'h4;
   localparam int unsigned CTRL_W       = 32'h3;
   localparam int unsigned CTRL_ALT_DIS = 32'h0;
   localparam int unsigned CTRL_OUT_EN  = 32'h1;
   localparam int unsigned EV_W         = 32'h2;
   localparam int unsigned EV_ALT       = 32'h0;
   localparam int unsigned EV_UNDERVOLTAGE_LOCKOUT      = 32'h1;

   localparam int unsigned STS_ALT      = 32'h0;
   localparam int unsigned STS_BIAS     = 32'h1;
   localparam int unsigned STS_SERIAL   = 32'h2;
   localparam int unsigned STS_DORMANT  = 32'h3;
   localparam int unsigned STS_BUCK     = 32'h4;
   localparam int unsigned STS_TWO_PH   = 32'h6;
   localparam int unsigned STS_FPWM     = 32'h8;
   localparam int unsigned STS_TRACK    = 32'hA;
   localparam int unsigned STS_SLAVE    = 32'h10;

   // Lowest selection code means a shorted second resistor
   localparam logic [3:0] SEL_TWO_PHASE_CODE = 4'h0;

   typedef enum logic [2:0] {
      ST_OFF,
      ST_WAKE,
      ST_RUN,
      ST_DORMANT
   } bec_state_t;

endpackage

// ---- hw/bec_sync.sv ----
`timescale 1ns/1ns
module bec_sync #(
   parameter int unsigned W    = 32'h1,
   parameter logic [W-1:0] INIT = '0
) (
   input  logic         clk,
   input  logic         rst_n,
   input  logic [W-1:0] d,
   output logic [W-1:0] q
);

   // ---------------------------------------------------------------
   // Three stages per bit, change taken once stages two and three agree
   // ---------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         logic s1;
         logic s2;
         logic s3;
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               s1 <= INIT[i];
               s2 <= INIT[i];
               s3 <= INIT[i];
            end else begin
               s1 <= d[i];
               s2 <= s1;
               s3 <= s2;
            end
         end
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               q[i] <= INIT[i];
            end else if (s2 == s3) begin
               q[i] <= s3;
            end
         end
      end
   endgenerate

endmodule

// ---- hw/bec_delay.sv ----
`timescale 1ns/1ns
module bec_delay #(
   parameter int unsigned CYC = 32'h1
) (
   input  logic clk,
   input  logic rst_n,
   input  logic run,
   input  logic restart,
   output logic done
);

   localparam int unsigned CW = $clog2(CYC + 32'h1);

   logic [CW-1:0] cnt;

   // ---------------------------------------------------------------
   // Done rises CYC edges after run goes high or after a restart
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt  <= '0;
         done <= 1'b0;
      end else if (!run || restart) begin
         cnt  <= '0;
         done <= 1'b0;
      end else if (!done) begin
         if (cnt == CW'(CYC - 32'h1)) begin
            done <= 1'b1;
         end else begin
            cnt <= cnt + 1'b1;
         end
      end
   end

endmodule

// ---- hw/bec_top.sv ----
`timescale 1ns/1ns
// Notes on behaviour
// - Bias regulators run from main supply when alt disabled or alt below level.
// - Bias regulators use alternative input only when enabled and above level.
// - Bias circuitry on whenever serial-enable or either output-enable pin is high and main supply is above reset threshold.
// - Selection codes are sampled once the logic bias supply is stable.
// - Serial interface active only with valid main and bias supplies.
// - After shutdown, bias starts on main supply, may switch to alternative later.
// - Switch-over sets an event flag; a status bit shows the selected input.
// - Output enabled when its enable pin is high; host drives pins firmly.
// - Enable-pin wake waits the start-up delay before passing enables on.
// - Each buck enable is pin OR register bit.
// - Main supply below falling threshold shuts all bucks off at once.
// - After undervoltage, stay dormant until main supply passes rising threshold.
// - Main supply at reset threshold drops bias, clears registers, enters shutdown.
// - Two-phase configuration holds second power-good pin low.
// - Low forced-PWM pin or clock on it selects forced PWM, clock tracked.
// - Interrupt pin is open-drain, active low, only pulls low.
// - Three-level address pin picks one of three slave addresses.
// - Defaults load from selection codes; host may overwrite them later.
// - Defaults held until all enables low or reset; shutdown clears registers.
module bec_top #(
   parameter int unsigned STARTUP_CYC    = bec_pkg::STARTUP_DELAY_CYC,
   parameter int unsigned TRACK_CYC      = bec_pkg::TRACK_TIMEOUT_CYC,
   // Slave addresses, values arbitrary
   parameter logic [6:0]  SLAVE_ADR_BIAS = 7'h20,
   parameter logic [6:0]  SLAVE_ADR_GND  = 7'h21,
   parameter logic [6:0]  SLAVE_ADR_OPEN = 7'h22
) (
   input  logic        clk,
   input  logic        rst_n,
   input  logic        wb_cyc_i,
   input  logic        wb_stb_i,
   input  logic        wb_we_i,
   input  logic [7:0]  wb_adr_i,
   input  logic [3:0]  wb_sel_i,
   input  logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic        wb_ack_o,
   input  logic        serial_enable_pin,
   input  logic        output1_enable_pin,
   input  logic        output2_enable_pin,
   input  logic        forced_pwm1_n,
   input  logic        forced_pwm2_n,
   input  logic        main_supply_por_ok,
   input  logic        main_supply_undervoltage_lockout_low,
   input  logic        main_supply_undervoltage_lockout_clear,
   input  logic        logic_bias_supply_ok,
   input  logic        alt_supply_above_swo,
   input  logic        addr_tie_high,
   input  logic        addr_tie_low,
   input  logic        buck1_good,
   input  logic        buck2_good,
   input  logic [3:0]  default_select1_code,
   input  logic [3:0]  default_select2_code,
   output logic        bias_enable,
   output logic        bias_from_alt,
   output logic        serial_active,
   output logic        select_sample,
   output logic [1:0]  buck_enable,
   output logic [1:0]  forced_pwm_mode,
   output logic [1:0]  freq_track,
   output logic        two_phase,
   output logic [6:0]  i2c_slave_addr,
   output logic        irq_out_n_o,
   output logic        irq_out_n_oe_n,
   output logic        power_good1_pin_o,
   output logic        power_good1_pin_oe_n,
   output logic        power_good2_pin_o,
   output logic        power_good2_pin_oe_n
);

   localparam int unsigned NO    = bec_pkg::NUM_OUT;
   localparam int unsigned SW    = bec_pkg::SEL_W;
   localparam int unsigned PIN_W = 32'h8 + 32'h3 * NO + SW * NO;
   localparam logic [PIN_W-1:0] PIN_INIT = PIN_W'(5'h18);

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   logic [PIN_W-1:0]    pin_raw;
   logic [PIN_W-1:0]    pin_s;
   logic [SW-1:0]       default_select1_pin_s;
   logic [SW-1:0]       default_select2_pin_s;
   logic [NO-1:0]       good_s;
   logic [NO-1:0]       fpwm_n_s;
   logic [NO-1:0]       en_s;
   logic                adr_hi_s;
   logic                adr_lo_s;
   logic                alt_ok_s;
   logic                vdd_ok_s;
   logic                uv_clear_s;
   logic                uv_low_s;
   logic                por_ok_s;
   logic                ser_en_s;

   assign pin_raw = {default_select2_code, default_select1_code, buck2_good, buck1_good,
                     addr_tie_low, addr_tie_high, alt_supply_above_swo, logic_bias_supply_ok,
                     main_supply_undervoltage_lockout_clear, main_supply_undervoltage_lockout_low, main_supply_por_ok,
                     forced_pwm2_n, forced_pwm1_n, output2_enable_pin, output1_enable_pin,
                     serial_enable_pin};

   bec_sync #(
      .W    (PIN_W),
      .INIT (PIN_INIT)
   ) u_sync (
      .clk   (clk),
      .rst_n (rst_n),
      .d     (pin_raw),
      .q     (pin_s)
   );

   assign {default_select2_pin_s, default_select1_pin_s, good_s, adr_lo_s, adr_hi_s, alt_ok_s, vdd_ok_s, uv_clear_s,
           uv_low_s, por_ok_s, fpwm_n_s, en_s, ser_en_s} = pin_s;

   // ---------------------------------------------------------------
   // Power state machine
   // ---------------------------------------------------------------
   bec_pkg::bec_state_t state;
   bec_pkg::bec_state_t next_state;
   logic                wake_req;
   logic                woke_by_en;
   logic                dly_done;
   logic                sampled;
   logic                sample_pulse;

   assign wake_req     = ser_en_s | (|en_s);
   assign sample_pulse = (state == bec_pkg::ST_WAKE) && vdd_ok_s && !sampled;

   always_comb begin
      next_state = state;
      case (state)
         bec_pkg::ST_OFF: begin
            if (wake_req) begin
               next_state = bec_pkg::ST_WAKE;
            end
         end
         bec_pkg::ST_WAKE: begin
            if (sampled && (dly_done || !woke_by_en)) begin
               next_state = bec_pkg::ST_RUN;
            end
         end
         bec_pkg::ST_RUN: begin
            if (uv_low_s) begin
               next_state = bec_pkg::ST_DORMANT;
            end
         end
         bec_pkg::ST_DORMANT: begin
            if (uv_clear_s && !uv_low_s) begin
               next_state = bec_pkg::ST_RUN;
            end
         end
         default: begin
            next_state = bec_pkg::ST_OFF;
         end
      endcase
      if (!wake_req || !por_ok_s) begin
         next_state = bec_pkg::ST_OFF;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= bec_pkg::ST_OFF;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         woke_by_en <= 1'b0;
      end else if (state == bec_pkg::ST_OFF) begin
         woke_by_en <= !ser_en_s;
      end
   end

   bec_delay #(
      .CYC (STARTUP_CYC)
   ) u_startup (
      .clk     (clk),
      .rst_n   (rst_n),
      .run     (state == bec_pkg::ST_WAKE),
      .restart (1'b0),
      .done    (dly_done)
   );

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sampled       <= 1'b0;
         select_sample <= 1'b0;
      end else begin
         sampled       <= (state != bec_pkg::ST_OFF) && (sampled || sample_pulse);
         select_sample <= sample_pulse;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bias_enable   <= 1'b0;
         serial_active <= 1'b0;
      end else begin
         bias_enable   <= next_state != bec_pkg::ST_OFF;
         serial_active <= (state != bec_pkg::ST_OFF) && por_ok_s && vdd_ok_s;
      end
   end

   // ---------------------------------------------------------------
   // Bus slave and registers
   // ---------------------------------------------------------------
   logic                wb_req;
   logic                wr_ok;
   logic [bec_pkg::CTRL_W-1:0] ctrl;
   logic [bec_pkg::EV_W-1:0]   ev;
   logic [bec_pkg::EV_W-1:0]   ev_set;
   logic [bec_pkg::EV_W-1:0]   ev_clr;
   logic [SW-1:0]       def1;
   logic [SW-1:0]       def2;
   logic                alt_next;
   logic [31:0]         status;

   assign wb_req = wb_cyc_i && wb_stb_i;
   assign wr_ok  = wb_req && wb_we_i && !wb_ack_o && wb_sel_i[0] && serial_active;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= wb_req && !wb_ack_o;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl <= '0;
      end else if (state == bec_pkg::ST_OFF) begin
         ctrl <= '0;
      end else if (wr_ok && wb_adr_i == bec_pkg::ADR_CTRL) begin
         ctrl <= wb_dat_i[bec_pkg::CTRL_W-1:0];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         def1 <= '0;
         def2 <= '0;
      end else if (state == bec_pkg::ST_OFF) begin
         def1 <= '0;
         def2 <= '0;
      end else if (sample_pulse) begin
         def1 <= default_select1_pin_s;
         def2 <= default_select2_pin_s;
      end else if (wr_ok && wb_adr_i == bec_pkg::ADR_DEFAULT) begin
         def1 <= wb_dat_i[SW-1:0];
         def2 <= wb_dat_i[2*SW-1:SW];
      end
   end

   // Main supply until bias is up, then alternative if allowed and valid
   assign alt_next = (state != bec_pkg::ST_OFF) && (state != bec_pkg::ST_WAKE) &&
                     !ctrl[bec_pkg::CTRL_ALT_DIS] && alt_ok_s;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bias_from_alt <= 1'b0;
      end else begin
         bias_from_alt <= alt_next;
      end
   end

   always_comb begin
      ev_set = '0;
      ev_clr = '0;
      ev_set[bec_pkg::EV_ALT]  = alt_next != bias_from_alt;
      ev_set[bec_pkg::EV_UNDERVOLTAGE_LOCKOUT] = (state == bec_pkg::ST_RUN) && (next_state == bec_pkg::ST_DORMANT);
      if (wr_ok && wb_adr_i == bec_pkg::ADR_EVENT) begin
         ev_clr = wb_dat_i[bec_pkg::EV_W-1:0];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ev <= '0;
      end else if (state == bec_pkg::ST_OFF) begin
         ev <= '0;
      end else begin
         ev <= (ev & ~ev_clr) | ev_set;
      end
   end

   always_comb begin
      status = '0;
      status[bec_pkg::STS_ALT]           = bias_from_alt;
      status[bec_pkg::STS_BIAS]          = bias_enable;
      status[bec_pkg::STS_SERIAL]        = serial_active;
      status[bec_pkg::STS_DORMANT]       = state == bec_pkg::ST_DORMANT;
      status[bec_pkg::STS_BUCK +: 2]     = buck_enable;
      status[bec_pkg::STS_TWO_PH]        = two_phase;
      status[bec_pkg::STS_FPWM +: 2]     = forced_pwm_mode;
      status[bec_pkg::STS_TRACK +: 2]    = freq_track;
      status[bec_pkg::STS_SLAVE +: 7]    = i2c_slave_addr;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wb_dat_o <= '0;
      end else if (wb_req && !wb_ack_o) begin
         case (wb_adr_i)
            bec_pkg::ADR_CTRL:    wb_dat_o <= 32'(ctrl);
            bec_pkg::ADR_STATUS:  wb_dat_o <= status;
            bec_pkg::ADR_EVENT:   wb_dat_o <= 32'(ev);
            bec_pkg::ADR_DEFAULT: wb_dat_o <= 32'({def2, def1});
            default:              wb_dat_o <= '0;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Buck enables and configuration
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         buck_enable <= '0;
      end else if (state == bec_pkg::ST_RUN && !uv_low_s) begin
         buck_enable <= en_s | ctrl[bec_pkg::CTRL_OUT_EN +: 2];
      end else begin
         buck_enable <= '0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         two_phase <= 1'b0;
      end else if (state == bec_pkg::ST_OFF) begin
         two_phase <= 1'b0;
      end else if (sample_pulse) begin
         two_phase <= default_select2_pin_s == bec_pkg::SEL_TWO_PHASE_CODE;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         i2c_slave_addr <= SLAVE_ADR_OPEN;
      end else if (adr_hi_s) begin
         i2c_slave_addr <= SLAVE_ADR_BIAS;
      end else if (adr_lo_s) begin
         i2c_slave_addr <= SLAVE_ADR_GND;
      end else begin
         i2c_slave_addr <= SLAVE_ADR_OPEN;
      end
   end

   genvar g;
   generate
      for (g = 0; g < NO; g++) begin : g_fpwm
         logic prev;
         logic quiet;
         logic edge_seen;
         assign edge_seen = prev != fpwm_n_s[g];
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               prev <= 1'b1;
            end else begin
               prev <= fpwm_n_s[g];
            end
         end
         bec_delay #(
            .CYC (TRACK_CYC)
         ) u_trk (
            .clk     (clk),
            .rst_n   (rst_n),
            .run     (1'b1),
            .restart (edge_seen),
            .done    (quiet)
         );
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               freq_track[g] <= 1'b0;
            end else if (edge_seen) begin
               freq_track[g] <= 1'b1;
            end else if (quiet) begin
               freq_track[g] <= 1'b0;
            end
         end
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               forced_pwm_mode[g] <= 1'b0;
            end else begin
               forced_pwm_mode[g] <= !fpwm_n_s[g] || edge_seen || freq_track[g];
            end
         end
      end
   endgenerate

   // ---------------------------------------------------------------
   // Open-drain pins, pulled low only
   // ---------------------------------------------------------------
   assign irq_out_n_o       = 1'b0;
   assign power_good1_pin_o = 1'b0;
   assign power_good2_pin_o = 1'b0;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_out_n_oe_n       <= 1'b1;
         power_good1_pin_oe_n <= 1'b0;
         power_good2_pin_oe_n <= 1'b0;
      end else begin
         irq_out_n_oe_n       <= ~(|ev);
         power_good1_pin_oe_n <= good_s[0] && buck_enable[0];
         power_good2_pin_oe_n <= !two_phase && good_s[1] && buck_enable[1];
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_off_wake;
      state == bec_pkg::ST_OFF && wake_req && por_ok_s;
   endsequence
   sequence s_en_wake_done;
      $rose(state == bec_pkg::ST_RUN) && $past(state == bec_pkg::ST_WAKE) && woke_by_en;
   endsequence

   property p_alt_dis;
      ctrl[bec_pkg::CTRL_ALT_DIS] |=> !bias_from_alt;
   endproperty
   a_alt_dis: assert property (p_alt_dis) else $error("alt used while disabled");
   property p_alt_use;
      bias_from_alt |-> $past(alt_ok_s) && !$past(ctrl[bec_pkg::CTRL_ALT_DIS]);
   endproperty
   a_alt_use: assert property (p_alt_use) else $error("alt used without cause");
   property p_bias_on;
      s_off_wake |=> bias_enable ##1 state == bec_pkg::ST_WAKE;
   endproperty
   a_bias_on: assert property (p_bias_on) else $error("bias not enabled on wake");
   property p_sample;
      sample_pulse |=> def1 == $past(default_select1_pin_s) && def2 == $past(default_select2_pin_s) && select_sample;
   endproperty
   a_sample: assert property (p_sample) else $error("selection not captured");
   property p_serial_off;
      !wake_req [*3] |-> !serial_active;
   endproperty
   a_serial_off: assert property (p_serial_off) else $error("serial active in shutdown");
   property p_wake_main;
      state == bec_pkg::ST_WAKE |=> !bias_from_alt;
   endproperty
   a_wake_main: assert property (p_wake_main) else $error("alt used during wake");
   property p_alt_flag;
      $changed(bias_from_alt) && $past(state != bec_pkg::ST_OFF) |-> ev[bec_pkg::EV_ALT];
   endproperty
   a_alt_flag: assert property (p_alt_flag) else $error("switch-over not flagged");
   property p_delay;
      s_en_wake_done |-> $past(dly_done);
   endproperty
   a_delay: assert property (p_delay) else $error("enables passed before delay");
   property p_or;
      state == bec_pkg::ST_RUN && !uv_low_s |=>
         buck_enable == ($past(en_s) | $past(ctrl[bec_pkg::CTRL_OUT_EN +: 2]));
   endproperty
   a_or: assert property (p_or) else $error("enable is not pin OR bit");
   property p_undervoltage_lockout;
      uv_low_s |=> buck_enable == '0;
   endproperty
   a_undervoltage_lockout: assert property (p_undervoltage_lockout) else $error("bucks on under undervoltage");
   property p_dormant;
      state == bec_pkg::ST_DORMANT && !uv_clear_s |=> state != bec_pkg::ST_RUN;
   endproperty
   a_dormant: assert property (p_dormant) else $error("left dormant too early");
   property p_por;
      !por_ok_s |=> state == bec_pkg::ST_OFF && !bias_enable ##1 ctrl == '0;
   endproperty
   a_por: assert property (p_por) else $error("reset threshold not honoured");
   property p_two_phase;
      two_phase |=> !power_good2_pin_oe_n;
   endproperty
   a_two_phase: assert property (p_two_phase) else $error("second power-good released");

endmodule

// ---- testbench/bec_host.sv ----
`timescale 1ns/1ns
module bec_host (
   input  wire logic       clk,
   input  wire logic [2:0] en_req,
   input  wire logic       irq_oe_n,
   output logic            ser_pin,
   output logic            en1_pin,
   output logic            en2_pin,
   output wire logic       irq_line
);
   initial {en2_pin, en1_pin, ser_pin} = 3'h0;
   // Firm levels, moved just after the edge
   always @(posedge clk) {en2_pin, en1_pin, ser_pin} <= en_req;
   // Host pull-up on the open-drain line
   assign irq_line = irq_oe_n ? 1'b1 : 1'b0;
endmodule

// ---- testbench/tb_bec_top.sv ----
`timescale 1ns/1ns
module tb_bec_top;
   logic clk = 0, rst_n = 0, cs = 0, we = 0, por = 1, ulo = 0, ucl = 1, alt = 0;
   logic [7:0] adr = 0;
   logic [31:0] wd = 0, rd;
   logic [2:0] en = 0;
   logic [1:0] gd = 2'h3, fp = 2'h3, at = 2'h0;
   logic [3:0] s2 = 4'h5;
   int mismatches = 0, cmp_count = 0;
   wire logic [31:0] dato;
   wire logic [1:0] be, fm, ft;
   wire logic [6:0] sad;
   wire logic ack, bias, balt, sa, ioe, irq, p0, p1, p2, tp, pg1, pg2;
   always #10 clk = ~clk;
   bec_host u_host (.clk(clk), .en_req(en), .irq_oe_n(ioe), .ser_pin(p0), .en1_pin(p1),
      .en2_pin(p2), .irq_line(irq));
   bec_top #(.STARTUP_CYC(20), .TRACK_CYC(8)) u_dut (.clk(clk), .rst_n(rst_n),
      .wb_cyc_i(cs), .wb_stb_i(cs), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
      .wb_dat_i(wd), .wb_dat_o(dato), .wb_ack_o(ack), .serial_enable_pin(p0),
      .output1_enable_pin(p1), .output2_enable_pin(p2), .forced_pwm1_n(fp[0]),
      .forced_pwm2_n(fp[1]), .main_supply_por_ok(por), .main_supply_undervoltage_lockout_low(ulo),
      .main_supply_undervoltage_lockout_clear(ucl), .logic_bias_supply_ok(1'b1),
      .alt_supply_above_swo(alt), .addr_tie_high(at[0]), .addr_tie_low(at[1]),
      .buck1_good(gd[0]), .buck2_good(gd[1]), .default_select1_code(4'hA),
      .default_select2_code(s2), .bias_enable(bias), .bias_from_alt(balt),
      .serial_active(sa), .select_sample(), .buck_enable(be), .forced_pwm_mode(fm),
      .freq_track(ft), .two_phase(tp), .i2c_slave_addr(sad), .irq_out_n_o(),
      .irq_out_n_oe_n(ioe), .power_good1_pin_o(), .power_good1_pin_oe_n(pg1),
      .power_good2_pin_o(), .power_good2_pin_oe_n(pg2));
   task automatic summarize;
      $display("Counts: %0d compares, %0d mismatches", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e) begin
         mismatches++;
         $display("Error t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic w(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int i;
      i = 0;
      cs <= 1'b1;
      we <= wr;
      adr <= a;
      wd <= d;
      do begin
         @(posedge clk);
         i++;
      end while (ack !== 1'b1 && i < 20);
      if (ack !== 1'b1) begin
         mismatches++;
         summarize();
      end
      rd = dato;
      cs <= 1'b0;
      @(posedge clk);
   endtask
   initial begin
      w(4);
      rst_n <= 1'b1;
      w(2);
      chk({bias, sa, be, ioe}, 32'h1);
      $display("reset test done");
      en <= 3'h2;
      w(10);
      chk(bias, 1'b1);
      chk(sa, 1'b1);
      chk(be, 2'h0);
      w(30);
      chk(be, 2'h1);
      bus(0, 8'h0C, 0);
      chk(rd, 32'h5A);
      bus(1, 8'h00, 32'h4);
      w(2);
      chk(be, 2'h3);
      chk({tp, pg1, pg2}, 3'h3);
      bus(0, 8'h40, 0);
      chk(rd, 32'h0);
      $display("wake test done");
      at <= 2'h1;
      w(8);
      chk(sad, 7'h20);
      at <= 2'h2;
      w(8);
      chk(sad, 7'h21);
      at <= 2'h0;
      fp <= 2'h2;
      w(20);
      chk({sad, fm, ft}, {7'h22, 4'h4});
      repeat (6) begin
         fp[1] <= ~fp[1];
         w(2);
      end
      chk({fm, ft[1]}, 3'h7);
      fp <= 2'h3;
      w(20);
      chk({fm, ft}, 4'h0);
      $display("pin test done");
      alt <= 1'b1;
      w(10);
      chk(balt, 1'b1);
      bus(0, 8'h08, 0);
      chk(rd[0], 1'b1);
      chk(irq, 1'b0);
      bus(1, 8'h00, 32'h5);
      w(8);
      chk(balt, 1'b0);
      bus(1, 8'h08, 32'h3);
      w(2);
      chk(irq, 1'b1);
      $display("alt test done");
      ulo <= 1'b1;
      ucl <= 1'b0;
      w(8);
      chk(be, 2'h0);
      chk(irq, 1'b0);
      ulo <= 1'b0;
      w(8);
      chk(be, 2'h0);
      ucl <= 1'b1;
      w(8);
      chk(be, 2'h3);
      $display("undervoltage_lockout test done");
      en <= 3'h0;
      s2 <= 4'h0;
      w(8);
      chk(bias, 1'b0);
      en <= 3'h1;
      w(10);
      bus(0, 8'h00, 0);
      chk(rd, 32'h0);
      chk(be, 2'h0);
      bus(0, 8'h0C, 0);
      chk(rd, 32'hA);
      bus(1, 8'h00, 32'h6);
      w(2);
      chk({be, tp, pg1, pg2}, 5'h1E);
      por <= 1'b0;
      w(8);
      chk(bias, 1'b0);
      $display("shutdown test done");
      summarize();
   end
endmodule
